// File: ifpd_dev.sv
// device end: decodes serial words for the auxiliary pll
// assumes the controller keeps each link level for several ref_clk cycles
//
// What this block and the controller do together
// - with 8/9, divide values <= 23 banned
// - 8/9: 24-55 sparse, 56-262143 all legal
// - with 16/17, divide values <= 47 banned
// - 16/17: 48-239 only listed sparse sub-ranges
// - power-down bit 1 stops pll, pump high-z
// - auto power-up plus first word clears power-down
// - low chip enable keeps pll powered down
// - reference ratio equals 12-bit field, 3..4095
// - pump gain k gives k+1 unit steps
// - top four bits pick optional words; bit0 one
// - precedence: chip enable, auto power-up, power-down bit
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ns
module ifpd_dev
	import ifpd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	ifpd_ser_if.dev ser,
	output logic aux_pll_on,
	output logic aux_cp_hiz,
	output logic [18:0] aux_fb_div,
	output logic aux_presc_16,
	output logic [11:0] aux_ref_div,
	output logic [3:0] main_pump_gain,
	output logic [4:0] main_pump_mult,
	output logic [3:0] word_select_bits,
	output logic [2:0] opt_word_need,
	output logic access_fault,
	output logic aux_powerdown,
	output logic auto_powerup
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	localparam int B_CLK = 0;
	localparam int B_DATA = 1;
	localparam int B_LE = 2;
	localparam int B_CE = 3;

	logic [3:0] s1_ff;
	logic [3:0] s2_ff;
	logic [3:0] s3_ff;
	logic [3:0] st_ff;
	logic [3:0] agree;
	logic [3:0] nxt_st;
	logic [3:0] rise;

	// three stages per pin; s1 feeds s2 only
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_ff <= 4'h0;
			s2_ff <= 4'h0;
			s3_ff <= 4'h0;
		end else begin
			s1_ff <= {ser.chip_en, ser.ser_le, ser.ser_data, ser.ser_clk};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// a level counts once stages two and three agree
	assign agree = ~(s2_ff ^ s3_ff);
	assign nxt_st = (agree & s3_ff) | (~agree & st_ff);
	assign rise = nxt_st & ~st_ff;

	// accepted pin levels
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= 4'h0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// shift register and word decode
	// ----------------------------------------
	logic [WORD_W-1:0] shift_ff;
	logic [WORD_W-1:0] word;
	logic [SEL_W-1:0] sel;
	logic latch;
	logic wr_fb;
	logic wr_ref;
	logic wr_fast;
	logic wr_first;

	// msb first, taken on each accepted clock rise
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_ff <= '0;
		end else if (rise[B_CLK]) begin
			shift_ff <= {shift_ff[WORD_W-2:0], nxt_st[B_DATA]};
		end
	end

	// a latch-enable rise commits the shifted word
	assign word = shift_ff;
	assign sel = word[SEL_W-1:0];
	assign latch = rise[B_LE];
	assign wr_fb = latch && (sel == SEL_FB_DIV);
	assign wr_ref = latch && (sel == SEL_REF_GAIN);
	assign wr_fast = latch && (sel == SEL_FAST);
	assign wr_first = latch && !sel[FIRST_SEL_BIT];

	// ----------------------------------------
	// feedback divide word
	// ----------------------------------------
	logic [18:0] fb_div_ff;
	logic pd_ff;
	logic apu_ff;

	// divide value; legality is the controller's duty
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			fb_div_ff <= FB_RST;
		end else if (wr_fb) begin
			fb_div_ff <= word[FB_MSB:FB_LSB];
		end
	end

	// power-down bit; auto power-up clear beats a stale bit
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pd_ff <= PD_RST;
		end else if (wr_first && apu_ff) begin
			pd_ff <= 1'b0;
		end else if (wr_fb) begin
			pd_ff <= word[PD_BIT];
		end
	end

	// ----------------------------------------
	// fastlock word fields used here
	// ----------------------------------------
	logic presc_ff;
	logic apu_req_ff;

	// auto power-up enable and prescaler choice
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			apu_ff <= APU_RST;
			presc_ff <= PRESC_RST;
		end else if (wr_fast) begin
			apu_ff <= word[APU_BIT];
			presc_ff <= word[PRESC_BIT];
		end
	end

	// pending power-up request until the divide word rewrites the bit
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			apu_req_ff <= 1'b0;
		end else if (wr_first && apu_ff) begin
			apu_req_ff <= 1'b1;
		end else if (wr_fb) begin
			apu_req_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// reference and gain word
	// ----------------------------------------
	logic [11:0] ref_ff;
	logic [3:0] gain_ff;
	logic [3:0] acc_ff;

	// reference ratio, pump gain and access bits
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ref_ff <= REF_RST;
			gain_ff <= GAIN_RST;
			acc_ff <= ACC_RST;
		end else if (wr_ref) begin
			ref_ff <= word[REF_MSB:REF_LSB];
			gain_ff <= word[GAIN_MSB:GAIN_LSB];
			acc_ff <= word[ACC_MSB:ACC_LSB];
		end
	end

	// ----------------------------------------
	// derived outputs
	// ----------------------------------------
	logic off_ff;
	logic [4:0] mult_ff;
	logic fault_ff;

	// gain code k maps to k+1 unit steps
	function automatic logic [4:0] pump_mult(input logic [3:0] k);
		return {1'b0, k} + 5'h01;
	endfunction

	// chip enable first, then power-up request, then the bit
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			off_ff <= 1'b1;
		end else if (!st_ff[B_CE]) begin
			off_ff <= 1'b1;
		end else if (apu_req_ff) begin
			off_ff <= 1'b0;
		end else begin
			off_ff <= pd_ff;
		end
	end

	// pump magnitude and access-bit sanity
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mult_ff <= 5'h01;
			fault_ff <= 1'b0;
		end else begin
			mult_ff <= pump_mult(gain_ff);
			fault_ff <= !acc_ff[0];
		end
	end

	// ----------------------------------------
	// output drive
	// ----------------------------------------
	assign aux_pll_on = !off_ff;
	assign aux_cp_hiz = off_ff;
	assign aux_fb_div = fb_div_ff;
	assign aux_presc_16 = presc_ff;
	assign aux_ref_div = ref_ff;
	assign main_pump_gain = gain_ff;
	assign main_pump_mult = mult_ff;
	assign word_select_bits = acc_ff;
	assign opt_word_need = acc_ff[3:1];
	assign access_fault = fault_ff;
	assign aux_powerdown = pd_ff;
	assign auto_powerup = apu_ff;

endmodule // ifpd_dev

// File: ifpd_pkg.sv
// package for the auxiliary pll configuration link
// assumes a 100 MHz ref_clk on both ends and 24-bit serial words
package ifpd_pkg;

	// ----------------------------------------
	// serial word layout
	// ----------------------------------------
	localparam int WORD_W = 24;
	localparam int SEL_W = 4;
	localparam logic [3:0] SEL_FB_DIV = 4'h5;
	localparam logic [3:0] SEL_REF_GAIN = 4'h7;
	localparam logic [3:0] SEL_FAST = 4'h9;
	localparam int FIRST_SEL_BIT = 0;
	localparam int FB_LSB = 4;
	localparam int FB_MSB = 22;
	localparam int PD_BIT = 23;
	localparam int REF_LSB = 4;
	localparam int REF_MSB = 15;
	localparam int GAIN_LSB = 16;
	localparam int GAIN_MSB = 19;
	localparam int ACC_LSB = 20;
	localparam int ACC_MSB = 23;
	localparam int APU_BIT = 23;
	localparam int PRESC_BIT = 8;
	localparam logic [11:0] REF_MIN = 12'h003;

	// ----------------------------------------
	// reset values of the device fields
	// ----------------------------------------
	localparam logic PD_RST = 1'b1;
	localparam logic APU_RST = 1'b0;
	localparam logic PRESC_RST = 1'b1;
	localparam logic [18:0] FB_RST = 19'h000f0;
	localparam logic [11:0] REF_RST = 12'h003;
	localparam logic [3:0] GAIN_RST = 4'h0;
	localparam logic [3:0] ACC_RST = 4'h1;

	// ----------------------------------------
	// controller apb map
	// ----------------------------------------
	localparam logic [7:0] OFS_TX = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam int CTRL_SEND = 0;
	localparam int CTRL_CE = 1;
	localparam int CTRL_PRESC = 2;
	localparam int STAT_BUSY = 0;
	localparam int STAT_REFUSED = 1;
	localparam logic CE_RST = 1'b0;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_NS = 10;
	localparam int SER_HALF_NS = 50;
	localparam int SER_HALF_CYC = (SER_HALF_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		IFPD_IDLE = 2'b00,
		IFPD_SHIFT = 2'b01,
		IFPD_LATCH = 2'b11
	} ifpd_hst_t;

endpackage

// File: ifpd_ser_if.sv
// three-wire serial link plus chip enable between controller and device
// assumes both ends share ref_clk; the link is sampled, not clocked
`timescale 1ns/1ns
interface ifpd_ser_if;
	logic ser_clk;
	logic ser_data;
	logic ser_le;
	logic chip_en;

	modport host (
		output ser_clk,
		output ser_data,
		output ser_le,
		output chip_en
	);

	modport dev (
		input ser_clk,
		input ser_data,
		input ser_le,
		input chip_en
	);
endinterface

// File: ifpd_div_check.sv
// legality check of a feedback divide value for the chosen prescaler
// assumes the caller registers the result before it reaches a pin
`timescale 1ns/1ns
module ifpd_div_check (
	input wire logic [18:0] fb_div,
	input wire logic presc_16,
	output logic legal
);

	// ----------------------------------------
	// n = p*b + a needs b >= 3 and a <= b;
	// this yields exactly the sparse low ranges
	// ----------------------------------------
	function automatic logic div_ok(input logic [18:0] n, input logic p16);
		logic ok;
		ok = 1'b0;
		if (p16) begin
			ok = (n[18:4] >= 15'h0003) && ({11'h000, n[3:0]} <= n[18:4]);
		end else begin
			ok = !n[18] && (n[17:3] >= 15'h0003) && ({12'h000, n[2:0]} <= n[17:3]);
		end
		return ok;
	endfunction

	// check is purely combinational
	assign legal = div_ok(fb_div, presc_16);

endmodule // ifpd_div_check

// File: ifpd_host.sv
// controller end: apb registers drive the three-wire serial link
// assumes a zero-wait apb master on ref_clk
`timescale 1ns/1ns
module ifpd_host
	import ifpd_pkg::*;
#(
	parameter int HALF_CYC = SER_HALF_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	ifpd_ser_if.host ser
);

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic [WORD_W-1:0] tx_ff;
	logic ce_ff;
	logic presc_ff;
	logic refused_ff;
	logic setup;
	logic wr;
	logic mapped;
	logic busy;
	logic [31:0] rd_mux;

	assign setup = psel && !penable;
	assign wr = psel && penable && pready_ff && pwrite;
	assign mapped = (paddr == OFS_TX) || (paddr == OFS_CTRL) || (paddr == OFS_STAT);

	// read mux; unmapped reads give zero
	always_comb begin
		rd_mux = 32'h0;
		case (paddr)
			OFS_TX: rd_mux = {8'h00, tx_ff};
			OFS_CTRL: rd_mux = {29'h0, presc_ff, ce_ff, 1'b0};
			OFS_STAT: rd_mux = {30'h0, refused_ff, busy};
			default: rd_mux = 32'h0;
		endcase
	end

	// answer one cycle after setup
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup && !mapped;
			prdata_ff <= setup ? rd_mux : 32'h0;
		end
	end

	// word buffer and control levels
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_ff <= '0;
			ce_ff <= CE_RST;
			presc_ff <= PRESC_RST;
		end else if (wr && paddr == OFS_TX && !busy) begin
			tx_ff <= pwdata[WORD_W-1:0];
		end else if (wr && paddr == OFS_CTRL) begin
			ce_ff <= pwdata[CTRL_CE];
			presc_ff <= pwdata[CTRL_PRESC];
		end
	end

	// ----------------------------------------
	// legality of the buffered word
	// ----------------------------------------
	logic div_legal;
	logic legal;
	logic send_req;
	logic start;

	ifpd_div_check u_chk (
		.fb_div(tx_ff[FB_MSB:FB_LSB]),
		.presc_16(presc_ff),
		.legal(div_legal)
	);

	// refuse words the device must never see
	always_comb begin
		legal = 1'b1;
		case (tx_ff[SEL_W-1:0])
			SEL_FB_DIV: legal = div_legal;
			SEL_REF_GAIN: legal = (tx_ff[REF_MSB:REF_LSB] >= REF_MIN) && tx_ff[ACC_LSB];
			default: legal = 1'b1;
		endcase
	end

	assign send_req = wr && (paddr == OFS_CTRL) && pwdata[CTRL_SEND];
	assign start = send_req && !busy && legal;

	// sticky refusal; a new refusal wins over the clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			refused_ff <= 1'b0;
		end else if (send_req && (busy || !legal)) begin
			refused_ff <= 1'b1;
		end else if (wr && paddr == OFS_STAT && pwdata[STAT_REFUSED]) begin
			refused_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// serial engine
	// ----------------------------------------
	ifpd_hst_t state_ff;
	logic [WORD_W-1:0] sh_ff;
	logic [4:0] bit_ff;
	logic [7:0] cnt_ff;
	logic sclk_ff;
	logic le_ff;

	assign busy = (state_ff != IFPD_IDLE);

	// msb first; data changes while the clock is low
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= IFPD_IDLE;
			sh_ff <= '0;
			bit_ff <= 5'h00;
			cnt_ff <= 8'h00;
			sclk_ff <= 1'b0;
			le_ff <= 1'b0;
		end else begin
			case (state_ff)
				IFPD_IDLE: begin
					if (start) begin
						state_ff <= IFPD_SHIFT;
						sh_ff <= tx_ff;
						bit_ff <= 5'h00;
						cnt_ff <= 8'(HALF_CYC - 1);
					end
				end
				IFPD_SHIFT: begin
					if (cnt_ff != 8'h00) begin
						cnt_ff <= cnt_ff - 8'h01;
					end else begin
						cnt_ff <= 8'(HALF_CYC - 1);
						sclk_ff <= !sclk_ff;
						if (sclk_ff) begin
							sh_ff <= {sh_ff[WORD_W-2:0], 1'b0};
							bit_ff <= bit_ff + 5'h01;
							if (bit_ff == 5'(WORD_W - 1)) begin
								state_ff <= IFPD_LATCH;
								le_ff <= 1'b1;
							end
						end
					end
				end
				IFPD_LATCH: begin
					if (cnt_ff != 8'h00) begin
						cnt_ff <= cnt_ff - 8'h01;
					end else begin
						le_ff <= 1'b0;
						state_ff <= IFPD_IDLE;
					end
				end
				default: state_ff <= IFPD_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// output drive
	// ----------------------------------------
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign ser.ser_clk = sclk_ff;
	assign ser.ser_data = sh_ff[WORD_W-1];
	assign ser.ser_le = le_ff;
	assign ser.chip_en = ce_ff;

endmodule // ifpd_host

// File: ifpd_link_properties.sv
// checker for the serial link between controller and device
// assumes it sees the shared interface signals sampled on ref_clk
`timescale 1ns/1ns
module ifpd_link_properties
	import ifpd_pkg::*;
#(
	parameter int HALF_CYC = SER_HALF_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_le,
	input wire logic chip_en
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------
	// helper logic
	// ----------------------------------------
	logic clk_q_ff;
	logic [7:0] hi_ff;
	logic [7:0] le_ff;
	logic [5:0] bits_ff;
	logic [23:0] sh_ff;

	// run lengths of the high phases of clock and latch
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hi_ff <= 8'h00;
			le_ff <= 8'h00;
		end else begin
			hi_ff <= ser_clk ? hi_ff + 8'h01 : 8'h00;
			le_ff <= ser_le ? le_ff + 8'h01 : 8'h00;
		end
	end

	// bit count and shifted word of the current frame
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			clk_q_ff <= 1'b0;
			bits_ff <= 6'h00;
			sh_ff <= 24'h000000;
		end else begin
			clk_q_ff <= ser_clk;
			if (ser_le) begin
				bits_ff <= 6'h00;
			end else if (ser_clk && !clk_q_ff) begin
				bits_ff <= bits_ff + 6'h01;
				sh_ff <= {sh_ff[22:0], ser_data};
			end
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	sequence s_last_bit;
		$fell(ser_clk) && bits_ff == 6'd24;
	endsequence
	sequence s_latch;
		$rose(ser_le);
	endsequence
	property p_le_after_last;
		s_last_bit |-> ser_le;
	endproperty
	property p_bits24;
		s_latch |-> bits_ff == 6'd24;
	endproperty
	property p_clk_high;
		$fell(ser_clk) |-> hi_ff == HALF_CYC;
	endproperty
	property p_le_len;
		$fell(ser_le) |-> le_ff == HALF_CYC;
	endproperty
	property p_le_clk_low;
		ser_le |-> !ser_clk;
	endproperty
	property p_data_hold;
		ser_clk && $past(ser_clk) |-> $stable(ser_data);
	endproperty
	property p_ref_legal;
		s_latch and (sh_ff[3:0] == SEL_REF_GAIN) |-> sh_ff[15:4] >= REF_MIN && sh_ff[20];
	endproperty
	property p_fb_min;
		s_latch and (sh_ff[3:0] == SEL_FB_DIV) |-> sh_ff[22:7] >= 16'd3;
	endproperty

	a_le_after_last: assert property (p_le_after_last) else $error("no latch after bit 24");
	a_bits24: assert property (p_bits24) else $error("frame not 24 bits");
	a_clk_high: assert property (p_clk_high) else $error("clock high phase length");
	a_le_len: assert property (p_le_len) else $error("latch pulse length");
	a_le_clk_low: assert property (p_le_clk_low) else $error("clock high during latch");
	a_data_hold: assert property (p_data_hold) else $error("data moved in high phase");
	a_ref_legal: assert property (p_ref_legal) else $error("bad reference word sent");
	a_fb_min: assert property (p_fb_min) else $error("divide value too small");
endmodule // ifpd_link_properties

// File: test_if_pll_divider_config.sv
// self-checking bench for the controller and device pair
// assumes a 100 MHz ref_clk and a shortened serial half period
`timescale 1ns/1ns
module test_if_pll_divider_config
	import ifpd_pkg::*;
;
	localparam int H = 3;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, aux_pll_on, aux_cp_hiz, aux_presc_16, access_fault;
	logic aux_powerdown, auto_powerup;
	logic [18:0] aux_fb_div;
	logic [11:0] aux_ref_div, rf;
	logic [3:0] main_pump_gain, word_select_bits;
	logic [4:0] main_pump_mult;
	logic [2:0] opt_word_need;
	int fail_count = 0;
	int n_tests = 0;
	int seed = 32'h13cc;
	logic [31:0] r;
	logic [32:0] exp_rd[$];
	logic [52:0] exp_dev[$];
	logic m_pd = PD_RST, m_apu = APU_RST, m_dpr = PRESC_RST, m_req = 1'b0;
	logic m_ce = CE_RST, m_hpr = 1'b0, le_q = 1'b0, ce_q = 1'b0, ev;
	logic [18:0] m_fb = FB_RST;
	logic [11:0] m_ref = REF_RST;
	logic [3:0] m_gain = GAIN_RST, m_acc = ACC_RST;
	logic [19:0] fb_tab [15] = '{20'h17, 20'h18, 20'h1c, 20'h36, 20'h37, 20'h38, 20'h3ffff,
		20'h40000, 20'h8002f, 20'h80030, 20'h80034, 20'h800ee, 20'h800ef, 20'h800f0, 20'hfffff};
	wire logic [52:0] dev_now = {aux_pll_on, aux_cp_hiz, aux_fb_div, aux_presc_16, aux_ref_div,
		main_pump_gain, main_pump_mult, word_select_bits, opt_word_need, access_fault,
		aux_powerdown, auto_powerup};

	ifpd_ser_if ser_link ();
	ifpd_host #(.HALF_CYC(H)) u_ifpd_host (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ser(ser_link));
	ifpd_dev u_ifpd_dev (.ref_clk(ref_clk), .rst_b(rst_b), .ser(ser_link),
		.aux_pll_on(aux_pll_on), .aux_cp_hiz(aux_cp_hiz), .aux_fb_div(aux_fb_div),
		.aux_presc_16(aux_presc_16), .aux_ref_div(aux_ref_div), .main_pump_gain(main_pump_gain),
		.main_pump_mult(main_pump_mult), .word_select_bits(word_select_bits),
		.opt_word_need(opt_word_need), .access_fault(access_fault),
		.aux_powerdown(aux_powerdown), .auto_powerup(auto_powerup));
	ifpd_link_properties #(.HALF_CYC(H)) u_ifpd_link_properties (.ref_clk(ref_clk),
		.rst_b(rst_b), .ser_clk(ser_link.ser_clk), .ser_data(ser_link.ser_data),
		.ser_le(ser_link.ser_le), .chip_en(ser_link.chip_en));

	// ----------------------------------------
	// clock, compare and verdict
	// ----------------------------------------
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (fail_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------
	// apb driver and model
	// ----------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// hold the request until pready is sampled high at a rising edge
		@(posedge ref_clk);
		while (pready !== 1'b1) begin
			@(posedge ref_clk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		exp_rd.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	function automatic logic [52:0] dev_exp();
		logic on;
		on = m_ce & (m_req | !m_pd);
		return {on, !on, m_fb, m_dpr, m_ref, m_gain, m_gain + 5'd1, m_acc, m_acc[3:1],
			!m_acc[0], m_pd, m_apu};
	endfunction

	// divide values legal per prescaler, reference word needs ratio >= 3 and bit 20
	function automatic logic legal(input logic [23:0] w);
		logic [18:0] b;
		logic [18:0] a;
		b = m_hpr ? w[22:4] >> 4 : w[22:4] >> 3;
		a = m_hpr ? w[22:4] & 19'hf : w[22:4] & 19'h7;
		if (w[3:0] == SEL_FB_DIV) return b >= 3 && a <= b && (m_hpr || !w[22]);
		if (w[3:0] == SEL_REF_GAIN) return w[15:4] >= REF_MIN && w[20];
		return 1'b1;
	endfunction

	task automatic ctrl(input logic ce, input logic pr);
		if (ce !== m_ce) begin
			m_ce = ce;
			exp_dev.push_back(dev_exp());
		end
		m_hpr = pr;
		apb(1'b1, OFS_CTRL, {29'h0, pr, ce, 1'b0});
		repeat (8) @(posedge ref_clk);
	endtask

	task automatic send(input logic [23:0] w, input logic bsy);
		apb(1'b1, OFS_TX, {8'h00, w});
		apb(1'b1, OFS_CTRL, {29'h0, m_hpr, m_ce, 1'b1});
		if (!legal(w)) begin
			rd(OFS_STAT, 33'h2);
			apb(1'b1, OFS_STAT, 32'h2);
		end else begin
			if (w[3:0] == SEL_FB_DIV) {m_pd, m_fb, m_req} = {w[23:4], 1'b0};
			if (w[3:0] == SEL_REF_GAIN) {m_acc, m_gain, m_ref} = w[23:4];
			if (w[3:0] == SEL_FAST) {m_apu, m_dpr} = {w[23], w[8]};
			if (!w[0] && m_apu) {m_pd, m_req} = 2'b01;
			exp_dev.push_back(dev_exp());
			if (bsy) apb(1'b1, OFS_TX, 32'h00abcdef);
			if (bsy) rd(OFS_TX, {9'h0, w});
			while (!ser_link.ser_le) begin
				@(posedge ref_clk);
			end
			while (ser_link.ser_le) begin
				@(posedge ref_clk);
			end
			repeat (10) @(posedge ref_clk);
			rd(OFS_STAT, 33'h0);
		end
	endtask

	// ----------------------------------------
	// monitors: apb reads and device state after frames
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (psel && penable && pready && !pwrite) begin
			if (exp_rd.size() == 0) check(64'h1, 64'h0);
			else check({pslverr, prdata}, exp_rd.pop_front());
		end
	end

	always @(posedge ref_clk) begin
		ev = rst_b && ((le_q && !ser_link.ser_le) || (ce_q !== ser_link.chip_en));
		le_q = ser_link.ser_le;
		ce_q = ser_link.chip_en;
		if (ev) begin
			repeat (6) @(posedge ref_clk);
			if (exp_dev.size() == 0) check(64'h1, 64'h0);
			else check(dev_now, exp_dev.pop_front());
		end
	end

	// watchdog well beyond the expected run length
	initial begin
		repeat (40000) @(posedge ref_clk);
		fail_count++;
		results();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		check(dev_now, dev_exp());
		rd(OFS_STAT, 33'h0);
		rd(8'h0c, 33'h1_0000_0000);
		r = $random(seed);
		apb(1'b1, OFS_TX, r);
		rd(OFS_TX, {9'h0, r[23:0]});
		ctrl(1'b1, 1'b0);
		send({1'b1, 14'h0, r[0], 4'h0, SEL_FAST}, 1'b1);
		send({r[23:4], 4'h0}, 1'b0);
		foreach (fb_tab[k]) begin
			if (fb_tab[k][19] !== m_hpr) ctrl(m_ce, fb_tab[k][19]);
			r = $random(seed);
			send({r[0], fb_tab[k][18:0], SEL_FB_DIV}, 1'b0);
		end
		send({1'b0, fb_tab[13][18:0], SEL_FB_DIV}, 1'b0);
		ctrl(1'b0, m_hpr);
		send({r[23:4], 4'h0}, 1'b0);
		ctrl(1'b1, m_hpr);
		for (int k = 0; k < 16; k++) begin
			r = $random(seed);
			rf = (k == 15) ? 12'hfff : (k == 0 || r[15:4] < 12'h3) ? 12'h3 : r[15:4];
			send({r[18:16], 1'b1, k[3:0], rf, SEL_REF_GAIN}, 1'b0);
		end
		send({4'h1, 4'h0, 12'h2, SEL_REF_GAIN}, 1'b0);
		send({4'h2, 4'h0, 12'h10, SEL_REF_GAIN}, 1'b0);
		results();
	end
endmodule // test_if_pll_divider_config
